// ===== shared/iec_map.svh
`ifndef IEC_MAP_SVH
`define IEC_MAP_SVH

// ----------------------------------------------------------------------
// register addresses, one byte command form and one 16-bit form
// ----------------------------------------------------------------------
`define IEC_CMD_SUNLIGHT        8'he0
`define IEC_CMD_NOISE           8'he1
`define IEC_CMD_SHARPEN         8'he2
`define IEC_CMD_COLOUR          8'he3
`define IEC_PAR_SUNLIGHT        16'he000
`define IEC_PAR_NOISE           16'he100
`define IEC_PAR_SHARPEN         16'he200
`define IEC_PAR_COLOUR          16'he300

// ----------------------------------------------------------------------
// register width, reset value and masks of the bits that are stored
// ----------------------------------------------------------------------
`define IEC_REG_W               8
`define IEC_REG_RESET           8'h00
`define IEC_MASK_SUNLIGHT       8'h1f
`define IEC_MASK_NOISE          8'h13
`define IEC_MASK_SHARPEN        8'h1f
`define IEC_MASK_COLOUR         8'h01

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IEC_SUN_EN_BIT          4
`define IEC_SUN_LVL_MSB         3
`define IEC_SUN_LVL_LSB         0
`define IEC_NR_EN_BIT           4
`define IEC_NR_LVL_MSB          1
`define IEC_NR_LVL_LSB          0
`define IEC_SHP_EN_BIT          4
`define IEC_SHP_GAIN_MSB        3
`define IEC_SHP_GAIN_LSB        0
`define IEC_CC_EN_BIT           0

`endif

// ===== shared/iec_pkg.sv
`default_nettype none

package iec_pkg;

    // ------------------------------------------------------------------
    // register slots of the bank, in address order
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IEC_SLOT_SUNLIGHT,
        IEC_SLOT_NOISE,
        IEC_SLOT_SHARPEN,
        IEC_SLOT_COLOUR
    } iec_slot_e;

    // ------------------------------------------------------------------
    // which write port a decoded access came from
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IEC_SRC_NONE,
        IEC_SRC_CMD,
        IEC_SRC_PAR
    } iec_src_e;

    typedef logic [7:0] iec_byte_t;

endpackage

`default_nettype wire

// ===== design/iec_shadow_reg.sv
`include "iec_map.svh"
`default_nettype none

// ----------------------------------------------------------------------
// one control register: a staged copy written at once by the host and a
// live copy that the pixel path sees, loaded only on an apply strobe
// ----------------------------------------------------------------------
module iec_shadow_reg
    import iec_pkg::*;
#(
    parameter int                W    = `IEC_REG_W,
    parameter logic [W-1:0]      MASK = '1
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            sw_reset,
    // host write
    input  wire logic            wr_en,
    input  wire logic [W-1:0]    wr_data,
    // frame boundary
    input  wire logic            apply,
    // state
    output logic [W-1:0]         live,
    output logic                 pending
);

    initial begin
        if (W < 1 || W > 16) begin
            $error("iec_shadow_reg: width out of range");
        end
    end

    logic [W-1:0] staged_r;
    logic [W-1:0] staged_nxt;
    logic [W-1:0] live_r;
    logic         pending_r;

    // unused upper bits are dropped on the way in
    assign staged_nxt = wr_en ? (wr_data & MASK) : staged_r;

    // ------------------------------------------------------------------
    // staged copy; software reset wins over a write in the same cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            staged_r <= W'(`IEC_REG_RESET);
        end else if (sw_reset) begin
            staged_r <= W'(`IEC_REG_RESET);
        end else begin
            staged_r <= staged_nxt;
        end
    end

    // ------------------------------------------------------------------
    // live copy; a write in the apply cycle is taken at that boundary
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            live_r <= W'(`IEC_REG_RESET);
        end else if (sw_reset) begin
            live_r <= W'(`IEC_REG_RESET);
        end else if (apply) begin
            live_r <= staged_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pending flag: a write sets it, apply clears it, apply also takes
    // that write so the two never race
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_r <= 1'b0;
        end else if (sw_reset) begin
            pending_r <= 1'b0;
        end else if (apply) begin
            pending_r <= 1'b0;
        end else if (wr_en) begin
            pending_r <= 1'b1;
        end
    end

    assign live    = live_r;
    assign pending = pending_r;

endmodule

`default_nettype wire

// ===== design/iec_regs.sv

`include "iec_map.svh"
`default_nettype none

module iec_regs
    import iec_pkg::*;
#(
    parameter int NUM_REGS = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sw_reset,
    // display serial link, decoded command byte with one parameter
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_param,
    // 16-bit serial interface, parameter address with data
    input  wire logic       par_wr,
    input  wire logic [15:0] par_addr,
    input  wire logic [7:0] par_data,
    // frame timing
    input  wire logic       frame_start,
    input  wire logic       frame_idle,
    // write handshake
    output logic            cmd_hit,
    output logic            par_hit,
    output logic            update_pending,
    // live settings for the pixel path
    output logic            sunlight_boost_enable,
    output logic [3:0]      sunlight_boost_level,
    output logic            noise_filter_enable,
    output logic [1:0]      noise_filter_level,
    output logic            sharpening_enable,
    output logic [3:0]      sharpening_gain,
    output logic            colour_calibration_enable,
    // pixel stream through the noise filter stage
    input  wire logic [23:0] pix_raw,
    input  wire logic [23:0] pix_filtered,
    output logic [23:0]     pix_out
);

    initial begin
        if (NUM_REGS != 4) begin
            $error("iec_regs: the bank holds exactly four registers");
        end
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic            cmd_match;
    logic            par_match;
    iec_slot_e       cmd_slot;
    iec_slot_e       par_slot;
    iec_src_e        src;
    iec_slot_e       wr_slot;
    iec_byte_t       wr_byte;
    logic [NUM_REGS-1:0] wr_vec;

    // command byte form; no power state gates the decode
    always_comb begin
        cmd_match = 1'b1;
        cmd_slot  = IEC_SLOT_SUNLIGHT;
        if (cmd_code == `IEC_CMD_SUNLIGHT) begin
            cmd_slot = IEC_SLOT_SUNLIGHT;
        end else if (cmd_code == `IEC_CMD_NOISE) begin
            cmd_slot = IEC_SLOT_NOISE;
        end else if (cmd_code == `IEC_CMD_SHARPEN) begin
            cmd_slot = IEC_SLOT_SHARPEN;
        end else if (cmd_code == `IEC_CMD_COLOUR) begin
            cmd_slot = IEC_SLOT_COLOUR;
        end else begin
            cmd_match = 1'b0;
        end
    end

    // 16-bit form; only parameter index 00 of each register exists
    always_comb begin
        par_match = 1'b1;
        par_slot  = IEC_SLOT_SUNLIGHT;
        if (par_addr == `IEC_PAR_SUNLIGHT) begin
            par_slot = IEC_SLOT_SUNLIGHT;
        end else if (par_addr == `IEC_PAR_NOISE) begin
            par_slot = IEC_SLOT_NOISE;
        end else if (par_addr == `IEC_PAR_SHARPEN) begin
            par_slot = IEC_SLOT_SHARPEN;
        end else if (par_addr == `IEC_PAR_COLOUR) begin
            par_slot = IEC_SLOT_COLOUR;
        end else begin
            par_match = 1'b0;
        end
    end

    // the two ports are alternatives; the command link wins a collision
    assign cmd_hit = cmd_wr & cmd_match;
    assign par_hit = par_wr & par_match & ~cmd_hit;

    always_comb begin
        src     = IEC_SRC_NONE;
        wr_slot = IEC_SLOT_SUNLIGHT;
        wr_byte = 8'h00;
        if (cmd_hit) begin
            src     = IEC_SRC_CMD;
            wr_slot = cmd_slot;
            wr_byte = cmd_param;
        end else if (par_hit) begin
            src     = IEC_SRC_PAR;
            wr_slot = par_slot;
            wr_byte = par_data;
        end
    end

    // ------------------------------------------------------------------
    // register slots
    // ------------------------------------------------------------------
    localparam logic [NUM_REGS*8-1:0] SLOT_MASKS = {
        `IEC_MASK_COLOUR,
        `IEC_MASK_SHARPEN,
        `IEC_MASK_NOISE,
        `IEC_MASK_SUNLIGHT
    };

    logic [7:0]          live_val [NUM_REGS];
    logic [NUM_REGS-1:0] pend_vec;
    logic                apply;

    // with frames halted (sleep, display off) there is no boundary to
    // wait for, so staged values go live at once
    assign apply = frame_start | frame_idle;

    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_slot
            assign wr_vec[i] = (src != IEC_SRC_NONE)
                             && (wr_slot == iec_slot_e'(i));
            iec_shadow_reg #(
                .W    (8),
                .MASK (SLOT_MASKS[i*8 +: 8])
            ) u_reg (
                .clk      (clk),
                .rst_n    (rst_n),
                .sw_reset (sw_reset),
                .wr_en    (wr_vec[i]),
                .wr_data  (wr_byte),
                .apply    (apply),
                .live     (live_val[i]),
                .pending  (pend_vec[i])
            );
        end
    endgenerate

    assign update_pending = |pend_vec;

    // ------------------------------------------------------------------
    // field extraction from the live copies
    // ------------------------------------------------------------------
    assign sunlight_boost_enable =
        live_val[IEC_SLOT_SUNLIGHT][`IEC_SUN_EN_BIT];
    assign sunlight_boost_level =
        live_val[IEC_SLOT_SUNLIGHT][`IEC_SUN_LVL_MSB:`IEC_SUN_LVL_LSB];
    assign noise_filter_enable =
        live_val[IEC_SLOT_NOISE][`IEC_NR_EN_BIT];
    assign noise_filter_level =
        live_val[IEC_SLOT_NOISE][`IEC_NR_LVL_MSB:`IEC_NR_LVL_LSB];
    assign sharpening_enable =
        live_val[IEC_SLOT_SHARPEN][`IEC_SHP_EN_BIT];
    assign sharpening_gain =
        live_val[IEC_SLOT_SHARPEN][`IEC_SHP_GAIN_MSB:`IEC_SHP_GAIN_LSB];
    assign colour_calibration_enable =
        live_val[IEC_SLOT_COLOUR][`IEC_CC_EN_BIT];

    // ------------------------------------------------------------------
    // noise filter bypass, registered so the pixel output is a flop
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pix_out <= 24'h000000;
        end else if (noise_filter_enable) begin
            pix_out <= pix_filtered;
        end else begin
            pix_out <= pix_raw;
        end
    end

endmodule

`default_nettype wire

// ===== testbench/iec_regs_properties.sv
`default_nettype none
module iec_regs_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        sw_reset,
    // host and frame inputs
    input wire logic        cmd_wr,
    input wire logic [7:0]  cmd_code,
    input wire logic        par_wr,
    input wire logic [15:0] par_addr,
    input wire logic        frame_start,
    input wire logic        frame_idle,
    // outputs under watch
    input wire logic        cmd_hit,
    input wire logic        par_hit,
    input wire logic        update_pending,
    input wire logic        sharpening_enable,
    input wire logic [3:0]  sharpening_gain,
    input wire logic        noise_filter_enable,
    input wire logic        colour_calibration_enable,
    input wire logic [23:0] pix_raw,
    input wire logic [23:0] pix_filtered,
    input wire logic [23:0] pix_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // an apply edge is a frame boundary or a stopped panel
    wire logic apply = frame_start | frame_idle;
    wire logic wr_any = cmd_hit | par_hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CMD_DECODE: assert property (
        cmd_wr && cmd_code[7:2] == 6'h38 |-> cmd_hit) else $error("cmd miss");
    AST_PAR_DECODE: assert property (
        par_wr && !cmd_hit && par_addr[15:10] == 6'h38 && par_addr[7:0] == 8'h00
        |-> par_hit) else $error("par miss");
    AST_PAR_STRAY: assert property (
        par_hit |-> par_wr && !cmd_hit && par_addr[7:0] == 8'h00)
        else $error("par stray hit");
    AST_STAGE: assert property (
        wr_any && !apply && !sw_reset |=> update_pending) else $error("no pend");
    AST_HOLD: assert property (
        !apply && !sw_reset |=> $stable(sharpening_gain) &&
        $stable(sharpening_enable)) else $error("live moved mid frame");
    AST_APPLY: assert property (
        apply && !wr_any |=> !update_pending) else $error("pend stuck");
    AST_SW_CLEAR: assert property (
        sw_reset |=> !update_pending && sharpening_gain == 4'h0 &&
        !sharpening_enable && !noise_filter_enable &&
        !colour_calibration_enable) else $error("sw reset left state");
    AST_PIX_SEL: assert property (
        !sw_reset |=> pix_out == ($past(noise_filter_enable) ?
        $past(pix_filtered) : $past(pix_raw))) else $error("pixel select");

    cover property (cmd_hit && frame_idle);
    cover property (par_hit ##1 update_pending ##[1:20] frame_start);
    cover property (sw_reset && update_pending);
endmodule
`default_nettype wire

// ===== testbench/iec_host.sv
`default_nettype none
module iec_host (
    // clock and decode seen by the host
    input wire logic         clk,
    input wire logic         hit,
    // command link and 16-bit link
    output var logic         cmd_wr,
    output var logic [7:0]   cmd_code,
    output var logic [7:0]   cmd_param,
    output var logic         par_wr,
    output var logic [15:0]  par_addr,
    output var logic [7:0]   par_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // both links idle from time zero
    initial begin
        cmd_wr = 1'b0;
        par_wr = 1'b0;
        cmd_code = 8'h00;
        cmd_param = 8'h00;
        par_addr = 16'h0000;
        par_data = 8'h00;
    end

    // one write; gap idle cycles first make a slow host
    task automatic send(input logic port, input logic [15:0] a,
                        input logic [7:0] d, input int gap,
                        output logic seen);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        cmd_wr <= ~port;
        par_wr <= port;
        cmd_code <= a[15:8];
        cmd_param <= d;
        par_addr <= a;
        par_data <= d;
        @(negedge clk);
        seen = hit;
        @(posedge clk);
        cmd_wr <= 1'b0;
        par_wr <= 1'b0;
        // released data is inverted so no stale copy can pass
        cmd_param <= ~d;
        par_data <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== testbench/iec_regs_tb.sv
`default_nettype none
module iec_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, sw_reset, frame_start, frame_idle;
    logic        cmd_wr, par_wr, cmd_hit, par_hit, update_pending;
    logic        sb_en, nf_en, sh_en, cc_en;
    logic [7:0]  cmd_code, cmd_param, par_data;
    logic [15:0] par_addr;
    logic [3:0]  sb_lvl, sh_gain;
    logic [1:0]  nf_lvl;
    logic [23:0] pix_raw, pix_filtered, pix_out;
    logic [7:0]  stg [4];
    logic [7:0]  liv [4];
    int          error_cnt, n_tests;
    wire logic [23:0] got = {10'h0, sb_en, sb_lvl, nf_en, nf_lvl,
                             sh_en, sh_gain, cc_en};

    iec_regs i_iec_regs (.clk(clk), .rst_n(rst_n), .sw_reset(sw_reset),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_param(cmd_param),
        .par_wr(par_wr), .par_addr(par_addr), .par_data(par_data),
        .frame_start(frame_start), .frame_idle(frame_idle),
        .cmd_hit(cmd_hit), .par_hit(par_hit),
        .update_pending(update_pending), .sunlight_boost_enable(sb_en),
        .sunlight_boost_level(sb_lvl), .noise_filter_enable(nf_en),
        .noise_filter_level(nf_lvl), .sharpening_enable(sh_en),
        .sharpening_gain(sh_gain), .colour_calibration_enable(cc_en),
        .pix_raw(pix_raw), .pix_filtered(pix_filtered), .pix_out(pix_out));
    iec_host i_iec_host (.clk(clk), .hit(cmd_hit | par_hit),
        .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_param(cmd_param),
        .par_wr(par_wr), .par_addr(par_addr), .par_data(par_data));

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // the whole run needs about a hundred cycles; 800 means a hang
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end

    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %0t got %h exp %h", $time, g, e);
        end
    endtask

    // expected live fields packed like got
    function automatic logic [23:0] want();
        return {10'h0, liv[0][4:0], liv[1][4], liv[1][1:0], liv[2][4:0],
                liv[3][0]};
    endfunction

    // one write; outside idle the live copy must not move yet
    task automatic wr(input logic port, input int idx, input logic [7:0] d,
                      input int gap);
        logic s;
        i_iec_host.send(port, {8'he0 + 8'(idx), 8'h00}, d, gap, s);
        stg[idx] = d & ((idx == 1) ? 8'h13 : (idx == 3) ? 8'h01 : 8'h1f);
        if (frame_idle) liv[idx] = stg[idx];
        @(negedge clk);
        chk(s, 1'b1);
        chk(update_pending, !frame_idle);
        chk(got, want());
    endtask

    task automatic frame();
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        liv = stg;
        @(negedge clk);
        chk(update_pending, 1'b0);
        chk(got, want());
    endtask

    // every register on both links, upper bits set on the first pass
    task automatic t_regs();
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 4; i++) begin
                wr(p[0], i, p ? 8'h3a : 8'hef, p);
            end
            frame();
        end
    endtask

    // unknown codes and parameter indices stage nothing
    task automatic t_refuse();
        logic s;
        i_iec_host.send(1'b0, 16'he400, 8'hff, 0, s);
        chk(s, 1'b0);
        i_iec_host.send(1'b1, 16'he001, 8'hff, 0, s);
        chk(s, 1'b0);
        @(negedge clk);
        chk(update_pending, 1'b0);
    endtask

    // stopped panel: a write goes live at its own edge
    task automatic t_idle();
        @(posedge clk);
        frame_idle <= 1'b1;
        wr(1'b1, 3, 8'h01, 0);
        wr(1'b0, 0, 8'h1c, 0);
        @(posedge clk);
        frame_idle <= 1'b0;
    endtask

    // noise stage output follows the live enable one cycle late
    task automatic t_pix();
        for (int e = 1; e >= 0; e--) begin
            wr(1'b0, 1, e ? 8'h12 : 8'h00, 0);
            frame();
            @(posedge clk);
            pix_raw <= 24'h5a5a5a;
            pix_filtered <= 24'ha5a5a5;
            @(posedge clk);
            @(negedge clk);
            chk(pix_out, e ? 24'ha5a5a5 : 24'h5a5a5a);
        end
    endtask

    // software reset wipes staged and live copies alike
    task automatic t_swr();
        wr(1'b0, 2, 8'h1f, 0);
        frame();
        wr(1'b1, 1, 8'h13, 1);
        @(posedge clk);
        sw_reset <= 1'b1;
        @(posedge clk);
        sw_reset <= 1'b0;
        stg = '{default: 8'h00};
        liv = stg;
        @(negedge clk);
        chk(update_pending, 1'b0);
        chk(got, want());
        frame();
    endtask

    initial begin
        rst_n = 1'b0;
        sw_reset = 1'b0;
        frame_start = 1'b0;
        frame_idle = 1'b0;
        pix_raw = 24'h000000;
        pix_filtered = 24'h000000;
        error_cnt = 0;
        n_tests = 0;
        stg = '{default: 8'h00};
        liv = stg;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(got, 24'h000000);
        t_regs();
        t_refuse();
        t_idle();
        t_pix();
        t_swr();
        print_verdict();
    end
endmodule

bind iec_regs iec_regs_properties i_iec_regs_properties (.clk(clk),
    .rst_n(rst_n), .sw_reset(sw_reset), .cmd_wr(cmd_wr),
    .cmd_code(cmd_code), .par_wr(par_wr), .par_addr(par_addr),
    .frame_start(frame_start), .frame_idle(frame_idle),
    .cmd_hit(cmd_hit), .par_hit(par_hit),
    .update_pending(update_pending),
    .sharpening_enable(sharpening_enable),
    .sharpening_gain(sharpening_gain),
    .noise_filter_enable(noise_filter_enable),
    .colour_calibration_enable(colour_calibration_enable),
    .pix_raw(pix_raw), .pix_filtered(pix_filtered), .pix_out(pix_out));
`default_nettype wire
